// ---- scr_defs.svh ----
// register offsets, field positions, reset values and timing counts of the config slice
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// register indices as printed; byte address is four times the index
`define SCR_IDX_MIDI_BASE_HIGH 8'h60
`define SCR_IDX_MIDI_BASE_LOW 8'h61
`define SCR_IDX_SLOW_CLOCK_CONFIG 8'hF0
`define SCR_IDX_FLOPPY_PORT_ROUTING 8'hF1
`define SCR_IDX_WAKE_KEY_CODE 8'hF2
`define SCR_IDX_WAKE_STATUS 8'hF3

// reset values
`define SCR_RST_MIDI_BASE_HIGH 8'h03
`define SCR_RST_MIDI_BASE_LOW 8'h30
`define SCR_RST_SLOW_CLOCK_CONFIG 8'h00
`define SCR_RST_FLOPPY_PORT_ROUTING 8'h00
`define SCR_RST_WAKE_KEY_CODE 8'h00

// field positions
`define SCR_BIT_SLOW_CLOCK_ABSENT 0
`define SCR_BIT_KEY_WAKE_OFF 1
`define SCR_BIT_STAT_WAKE 0
`define SCR_BIT_STAT_SLOW_SEEN 1
`define SCR_BIT_STAT_SLOW_LOST 2
`define SCR_MASK_MIDI_HIGH 8'h0F
`define SCR_MASK_MIDI_LOW 8'hFE
`define SCR_MASK_CFG2 8'h03

// slow clock watchdog: two nominal 32 kHz periods at 50 ns per cycle
`define SCR_CLK_PERIOD_NS 50
`define SCR_SLOW_PERIOD_NS 31250
`define SCR_SLOW_LOST_CYCLES ((2 * `SCR_SLOW_PERIOD_NS) / `SCR_CLK_PERIOD_NS)

`endif

// ---- scr_pkg.sv ----
// types shared by the config slice modules
`default_nettype none
package scr_pkg;
    typedef enum logic [1:0] {
        SCR_ROUTE_BY_PP_MODE = 2'b00,
        SCR_ROUTE_DRIVE1_PP = 2'b01,
        SCR_ROUTE_BOTH_PP = 2'b10,
        SCR_ROUTE_RESERVED = 2'b11
    } scr_route_e;

    typedef enum logic [1:0] {
        SCR_WK_IDLE = 2'b00,
        SCR_WK_ARMED = 2'b01,
        SCR_WK_HIT = 2'b10
    } scr_wake_e;
endpackage
`default_nettype wire

// ---- scr_wake_if.sv ----
// carrier between the register slice and the key wake logic
`timescale 1ns/10ps
`default_nettype none
interface scr_wake_if;
    logic slow_tick;
    logic logic_on;
    logic [7:0] wake_code;
    logic key_valid;
    logic [7:0] key_code;
    logic wake_clear;
    logic wake_flag;

    modport regs (output slow_tick, output logic_on, output wake_code, output key_valid,
        output key_code, output wake_clear, input wake_flag);
    modport wake (input slow_tick, input logic_on, input wake_code, input key_valid,
        input key_code, input wake_clear, output wake_flag);
endinterface
`default_nettype wire

// ---- scr_key_wake.sv ----
// wake-on-key logic, advanced only by gated slow clock ticks
`timescale 1ns/10ps
`default_nettype none
module scr_key_wake
    import scr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // link to the register slice
    scr_wake_if.wake wk
);
    scr_wake_e state_q;
    logic [7:0] key_q;
    logic flag_q;
    logic hit;

    ////////////////////////////////////////////////////////////////////////////////
    // keys are latched at system rate; comparison only runs on slow ticks
    always_ff @(posedge clk) begin
        if (srst || !wk.logic_on) begin
            key_q <= 8'h00;
        end else if (wk.key_valid) begin
            key_q <= wk.key_code;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !wk.logic_on) begin
            state_q <= SCR_WK_IDLE;
        end else if (wk.slow_tick) begin
            case (state_q)
                SCR_WK_IDLE: state_q <= SCR_WK_ARMED;
                SCR_WK_ARMED: state_q <= (key_q == wk.wake_code) ? SCR_WK_HIT : SCR_WK_ARMED;
                SCR_WK_HIT: state_q <= SCR_WK_IDLE;
                default: state_q <= SCR_WK_IDLE;
            endcase
        end
    end

    assign hit = wk.slow_tick && (state_q == SCR_WK_ARMED) && (key_q == wk.wake_code);

    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else if (hit) begin
            flag_q <= 1'b1;
        end else if (wk.wake_clear) begin
            flag_q <= 1'b0;
        end
    end

    assign wk.wake_flag = flag_q;
endmodule
`default_nettype wire

// ---- scr_cfg_top.sv ----
// configuration register slice: slow clock, key wake, floppy routing, midi base decode
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "scr_defs.svh"
module scr_cfg_top
    import scr_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // slow clock and keyboard
    input wire logic SLOW_CLOCK_INPUT_PIN,
    input wire logic KEY_VALID,
    input wire logic [7:0] KEY_CODE,
    output logic WAKE_EVENT,
    output logic SLOW_CLOCK_ABSENT_FLAG,
    output logic KEY_WAKE_LOGIC_OFF,
    // floppy on parallel port
    input wire logic FLOPPY_PORT_ROUTING_SELECT,
    input wire logic PP_MODE_DRIVE0_PP,
    input wire logic PP_MODE_DRIVE1_PP,
    output logic DRIVE0_ON_PP,
    output logic DRIVE1_ON_PP,
    // host io decode
    input wire logic IO_VALID,
    input wire logic [11:0] IO_ADDR,
    output logic MIDI_SELECT
);
    ////////////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] midi_base_addr_high_q;
    logic [7:0] midi_base_addr_low_q;
    logic [7:0] slow_clock_config_q;
    logic [7:0] floppy_port_routing_q;
    logic [7:0] wake_key_code_q;
    logic slow_seen_q;
    logic slow_lost_q;
    logic [31:0] prdata_q;
    logic drive0_pp_q;
    logic drive1_pp_q;
    logic midi_sel_q;
    logic slow_pin_q;
    logic [15:0] lost_cnt_q;

    logic setup;
    logic wr_en;
    logic addr_ok;
    logic [7:0] rd_byte;
    logic slow_rise;
    logic slow_tick;
    logic wake_clear;
    logic [7:0] wdat;
    logic drive0_pp_d;
    logic drive1_pp_d;
    scr_route_e route;

    scr_wake_if wk ();

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // register index carried in PADDR[9:2]; bits 11:10 and 1:0 must be zero
    function automatic logic idx_hit(input logic [11:0] addr, input logic [7:0] idx);
        idx_hit = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) && (addr[9:2] == idx);
    endfunction

    function automatic logic idx_mapped(input logic [11:0] addr);
        idx_mapped = idx_hit(addr, `SCR_IDX_MIDI_BASE_HIGH) || idx_hit(addr, `SCR_IDX_MIDI_BASE_LOW)
            || idx_hit(addr, `SCR_IDX_SLOW_CLOCK_CONFIG) || idx_hit(addr, `SCR_IDX_FLOPPY_PORT_ROUTING)
            || idx_hit(addr, `SCR_IDX_WAKE_KEY_CODE) || idx_hit(addr, `SCR_IDX_WAKE_STATUS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, read data captured in the setup cycle

    assign setup = PSEL && !PENABLE;
    assign addr_ok = idx_mapped(PADDR);
    assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
    assign wdat = PWDATA[7:0];
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;

    always_comb begin
        rd_byte = 8'h00;
        if (idx_hit(PADDR, `SCR_IDX_MIDI_BASE_HIGH)) begin
            rd_byte = midi_base_addr_high_q;
        end else if (idx_hit(PADDR, `SCR_IDX_MIDI_BASE_LOW)) begin
            rd_byte = midi_base_addr_low_q;
        end else if (idx_hit(PADDR, `SCR_IDX_SLOW_CLOCK_CONFIG)) begin
            rd_byte = slow_clock_config_q;
        end else if (idx_hit(PADDR, `SCR_IDX_FLOPPY_PORT_ROUTING)) begin
            rd_byte = floppy_port_routing_q;
        end else if (idx_hit(PADDR, `SCR_IDX_WAKE_KEY_CODE)) begin
            rd_byte = wake_key_code_q;
        end else if (idx_hit(PADDR, `SCR_IDX_WAKE_STATUS)) begin
            rd_byte = {5'h00, slow_lost_q, slow_seen_q, wk.wake_flag};
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !PWRITE) begin
            prdata_q <= {24'h000000, rd_byte};
        end
    end

    assign PRDATA = prdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // register writes; unused bits are never stored so they read zero

    always_ff @(posedge CLK) begin
        if (SRST) begin
            midi_base_addr_high_q <= `SCR_RST_MIDI_BASE_HIGH;
        end else if (wr_en && idx_hit(PADDR, `SCR_IDX_MIDI_BASE_HIGH)) begin
            midi_base_addr_high_q <= wdat & `SCR_MASK_MIDI_HIGH;
        end
    end

    // bit 0 forced to zero even if software breaks the write convention
    always_ff @(posedge CLK) begin
        if (SRST) begin
            midi_base_addr_low_q <= `SCR_RST_MIDI_BASE_LOW;
        end else if (wr_en && idx_hit(PADDR, `SCR_IDX_MIDI_BASE_LOW)) begin
            midi_base_addr_low_q <= wdat & `SCR_MASK_MIDI_LOW;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            slow_clock_config_q <= `SCR_RST_SLOW_CLOCK_CONFIG;
        end else if (wr_en && idx_hit(PADDR, `SCR_IDX_SLOW_CLOCK_CONFIG)) begin
            slow_clock_config_q <= wdat & `SCR_MASK_CFG2;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            floppy_port_routing_q <= `SCR_RST_FLOPPY_PORT_ROUTING;
        end else if (wr_en && idx_hit(PADDR, `SCR_IDX_FLOPPY_PORT_ROUTING)) begin
            floppy_port_routing_q <= wdat & `SCR_MASK_CFG2;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            wake_key_code_q <= `SCR_RST_WAKE_KEY_CODE;
        end else if (wr_en && idx_hit(PADDR, `SCR_IDX_WAKE_KEY_CODE)) begin
            wake_key_code_q <= wdat;
        end
    end

    // write one to a status bit clears it
    assign wake_clear = wr_en && idx_hit(PADDR, `SCR_IDX_WAKE_STATUS) && wdat[`SCR_BIT_STAT_WAKE];

    ////////////////////////////////////////////////////////////////////////////////
    // slow clock: edge detect, presence and watchdog

    always_ff @(posedge CLK) begin
        if (SRST) begin
            slow_pin_q <= 1'b0;
        end else begin
            slow_pin_q <= SLOW_CLOCK_INPUT_PIN;
        end
    end

    // a grounded pin must never be trusted to tick
    assign slow_rise = SLOW_CLOCK_INPUT_PIN && !slow_pin_q
        && !slow_clock_config_q[`SCR_BIT_SLOW_CLOCK_ABSENT];

    // ticks blocked while the wake logic is off, so it holds still
    assign slow_tick = slow_rise && !slow_clock_config_q[`SCR_BIT_KEY_WAKE_OFF];

    always_ff @(posedge CLK) begin
        if (SRST) begin
            slow_seen_q <= 1'b0;
        end else if (slow_rise) begin
            slow_seen_q <= 1'b1;
        end else if (wr_en && idx_hit(PADDR, `SCR_IDX_WAKE_STATUS) && wdat[`SCR_BIT_STAT_SLOW_SEEN]) begin
            slow_seen_q <= 1'b0;
        end
    end

    // counts only while the clock is declared present
    always_ff @(posedge CLK) begin
        if (SRST || slow_rise || slow_clock_config_q[`SCR_BIT_SLOW_CLOCK_ABSENT]) begin
            lost_cnt_q <= 16'h0000;
        end else if (lost_cnt_q != 16'(`SCR_SLOW_LOST_CYCLES)) begin
            lost_cnt_q <= lost_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            slow_lost_q <= 1'b0;
        end else if (lost_cnt_q == 16'(`SCR_SLOW_LOST_CYCLES) - 16'h0001) begin
            slow_lost_q <= 1'b1;
        end else if (wr_en && idx_hit(PADDR, `SCR_IDX_WAKE_STATUS) && wdat[`SCR_BIT_STAT_SLOW_LOST]) begin
            slow_lost_q <= 1'b0;
        end
    end

    assign SLOW_CLOCK_ABSENT_FLAG = slow_clock_config_q[`SCR_BIT_SLOW_CLOCK_ABSENT];
    assign KEY_WAKE_LOGIC_OFF = slow_clock_config_q[`SCR_BIT_KEY_WAKE_OFF];

    ////////////////////////////////////////////////////////////////////////////////
    // key wake logic

    assign wk.slow_tick = slow_tick;
    assign wk.logic_on = !slow_clock_config_q[`SCR_BIT_KEY_WAKE_OFF];
    assign wk.wake_code = wake_key_code_q;
    assign wk.key_valid = KEY_VALID;
    assign wk.key_code = KEY_CODE;
    assign wk.wake_clear = wake_clear;

    scr_key_wake u_key_wake (
        .clk(CLK),
        .srst(SRST),
        .wk(wk.wake)
    );

    assign WAKE_EVENT = wk.wake_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // floppy drive routing onto parallel port pins

    assign route = scr_route_e'(floppy_port_routing_q[1:0]);

    always_comb begin
        drive0_pp_d = 1'b0;
        drive1_pp_d = 1'b0;
        case (route)
            SCR_ROUTE_BY_PP_MODE: begin
                drive0_pp_d = PP_MODE_DRIVE0_PP;
                drive1_pp_d = PP_MODE_DRIVE1_PP;
            end
            SCR_ROUTE_DRIVE1_PP: begin
                drive1_pp_d = !FLOPPY_PORT_ROUTING_SELECT;
            end
            SCR_ROUTE_BOTH_PP: begin
                drive0_pp_d = !FLOPPY_PORT_ROUTING_SELECT;
                drive1_pp_d = !FLOPPY_PORT_ROUTING_SELECT;
            end
            // reserved code leaves the parallel port to the printer
            default: begin
                drive0_pp_d = 1'b0;
                drive1_pp_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            drive0_pp_q <= 1'b0;
            drive1_pp_q <= 1'b0;
        end else begin
            drive0_pp_q <= drive0_pp_d;
            drive1_pp_q <= drive1_pp_d;
        end
    end

    assign DRIVE0_ON_PP = drive0_pp_q;
    assign DRIVE1_ON_PP = drive1_pp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // midi base address decode; a two-byte window, bit 0 ignored

    always_ff @(posedge CLK) begin
        if (SRST) begin
            midi_sel_q <= 1'b0;
        end else begin
            midi_sel_q <= IO_VALID && (IO_ADDR[11:1] ==
                {midi_base_addr_high_q[3:0], midi_base_addr_low_q[7:1]});
        end
    end

    assign MIDI_SELECT = midi_sel_q;
endmodule
`default_nettype wire

// ---- scr_cfg_monitor.sv ----
// concurrent checks on the ports of the config register slice
`timescale 1ns/10ps
`default_nettype none
module scr_cfg_monitor (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // register bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    // slow clock and wake
    input wire logic WAKE_EVENT,
    input wire logic SLOW_CLOCK_ABSENT_FLAG,
    input wire logic KEY_WAKE_LOGIC_OFF,
    // floppy routing
    input wire logic FLOPPY_PORT_ROUTING_SELECT,
    input wire logic PP_MODE_DRIVE0_PP,
    input wire logic PP_MODE_DRIVE1_PP,
    input wire logic DRIVE0_ON_PP,
    input wire logic DRIVE1_ON_PP,
    // io decode
    input wire logic IO_VALID,
    input wire logic [11:0] IO_ADDR,
    input wire logic MIDI_SELECT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    logic wr_ok;
    logic rd_ok;
    logic [1:0] route_q;
    logic [11:1] base_q;
    assign wr_ok = PSEL && PENABLE && PWRITE;
    assign rd_ok = PSEL && PENABLE && !PWRITE;
    ////////////////////////////////////////////////////////////////
    // shadows kept apart from the slave so a stuck register shows up
    always_ff @(posedge CLK) begin
        if (SRST) begin
            route_q <= 2'h0;
        end else if (wr_ok && PADDR == 12'h3C4) begin
            route_q <= PWDATA[1:0];
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            base_q <= 11'h198;
        end else if (wr_ok && PADDR == 12'h180) begin
            base_q[11:8] <= PWDATA[3:0];
        end else if (wr_ok && PADDR == 12'h184) begin
            base_q[7:1] <= PWDATA[7:1];
        end
    end
    ////////////////////////////////////////////////////////////////
    a_absent_flag: assert property (wr_ok && PADDR == 12'h3C0 |=> SLOW_CLOCK_ABSENT_FLAG == $past(PWDATA[0]))
        else $error("absent flag does not follow config bit 0");
    a_key_off_flag: assert property (wr_ok && PADDR == 12'h3C0 |=> KEY_WAKE_LOGIC_OFF == $past(PWDATA[1]))
        else $error("key wake off flag does not follow config bit 1");
    a_wake_gated: assert property (KEY_WAKE_LOGIC_OFF [*3] ##0 !WAKE_EVENT |=> !WAKE_EVENT)
        else $error("wake event raised while key wake logic is off");
    a_route_by_mode: assert property (route_q == 2'h0 |=> DRIVE0_ON_PP == $past(PP_MODE_DRIVE0_PP)
        && DRIVE1_ON_PP == $past(PP_MODE_DRIVE1_PP))
        else $error("routing 00 does not follow parallel port mode");
    a_route_split: assert property (route_q == 2'h1 && !FLOPPY_PORT_ROUTING_SELECT
        |=> !DRIVE0_ON_PP && DRIVE1_ON_PP)
        else $error("routing 01 does not place only drive 1 on the port");
    a_route_both: assert property (route_q == 2'h2 && !FLOPPY_PORT_ROUTING_SELECT
        |=> DRIVE0_ON_PP && DRIVE1_ON_PP)
        else $error("routing 10 does not place both drives on the port");
    a_base_high_read: assert property (rd_ok && PADDR == 12'h180 |-> PRDATA == {28'h0, base_q[11:8]})
        else $error("base high read back wrong");
    a_base_low_read: assert property (rd_ok && PADDR == 12'h184 |-> PRDATA == {24'h0, base_q[7:1], 1'b0})
        else $error("base low read back wrong");
    a_midi_claim: assert property (1'b1 |=> MIDI_SELECT == $past(IO_VALID && IO_ADDR[11:1] == base_q))
        else $error("midi select does not match the base decode");
endmodule
`default_nettype wire

// ---- scr_cfg_tb.sv ----
// self-checking bench of the config register slice with a reference model
`timescale 1ns/10ps
`default_nettype none
`include "scr_defs.svh"
bind scr_cfg_top scr_cfg_monitor mon (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .WAKE_EVENT(WAKE_EVENT),
    .SLOW_CLOCK_ABSENT_FLAG(SLOW_CLOCK_ABSENT_FLAG), .KEY_WAKE_LOGIC_OFF(KEY_WAKE_LOGIC_OFF),
    .FLOPPY_PORT_ROUTING_SELECT(FLOPPY_PORT_ROUTING_SELECT), .PP_MODE_DRIVE0_PP(PP_MODE_DRIVE0_PP),
    .PP_MODE_DRIVE1_PP(PP_MODE_DRIVE1_PP), .DRIVE0_ON_PP(DRIVE0_ON_PP), .DRIVE1_ON_PP(DRIVE1_ON_PP),
    .IO_VALID(IO_VALID), .IO_ADDR(IO_ADDR), .MIDI_SELECT(MIDI_SELECT));
module testbench;
    logic CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SLOW_CLOCK_INPUT_PIN, KEY_VALID;
    logic WAKE_EVENT, SLOW_CLOCK_ABSENT_FLAG, KEY_WAKE_LOGIC_OFF, FLOPPY_PORT_ROUTING_SELECT;
    logic PP_MODE_DRIVE0_PP, PP_MODE_DRIVE1_PP, DRIVE0_ON_PP, DRIVE1_ON_PP, IO_VALID, MIDI_SELECT;
    logic [11:0] PADDR, IO_ADDR, base;
    logic [31:0] PWDATA, PRDATA, r;
    logic [7:0] KEY_CODE;
    logic [11:0] regs_a [6] = '{12'h180, 12'h184, 12'h3C0, 12'h3C4, 12'h3C8, 12'h181};
    int num_errors = 0;
    int samples_checked = 0;
    int m_hi = 3, m_lo = 8'h30, m_cfg = 0, m_rt = 0, m_key = 0, m_st = 0;
    logic e0, e1;
    scr_cfg_top dut (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SLOW_CLOCK_INPUT_PIN(SLOW_CLOCK_INPUT_PIN), .KEY_VALID(KEY_VALID), .KEY_CODE(KEY_CODE),
        .WAKE_EVENT(WAKE_EVENT), .SLOW_CLOCK_ABSENT_FLAG(SLOW_CLOCK_ABSENT_FLAG),
        .KEY_WAKE_LOGIC_OFF(KEY_WAKE_LOGIC_OFF), .FLOPPY_PORT_ROUTING_SELECT(FLOPPY_PORT_ROUTING_SELECT),
        .PP_MODE_DRIVE0_PP(PP_MODE_DRIVE0_PP), .PP_MODE_DRIVE1_PP(PP_MODE_DRIVE1_PP),
        .DRIVE0_ON_PP(DRIVE0_ON_PP), .DRIVE1_ON_PP(DRIVE1_ON_PP), .IO_VALID(IO_VALID), .IO_ADDR(IO_ADDR),
        .MIDI_SELECT(MIDI_SELECT));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic [31:0] exp;
        case (a)
            12'h180: exp = m_hi;
            12'h184: exp = m_lo;
            12'h3C0: exp = m_cfg;
            12'h3C4: exp = m_rt;
            12'h3C8: exp = m_key;
            12'h3CC: exp = m_st;
            default: exp = 0;
        endcase
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        // no timeout here; a wait that never sees PREADY ends only at the bench watchdog
        while (PREADY !== 1'b1) begin
            @(posedge CLK);
        end
        chk("pready", 1, PREADY);
        chk("pslverr", !(a inside {12'h180, 12'h184, 12'h3C0, 12'h3C4, 12'h3C8, 12'h3CC}), PSLVERR);
        if (!w) chk("prdata", exp, PRDATA);
        else if (a == 12'h180) m_hi = d & 32'h0F;
        else if (a == 12'h184) m_lo = d & 32'hFE;
        else if (a == 12'h3C0) m_cfg = d & 32'h03;
        else if (a == 12'h3C4) m_rt = d & 32'h03;
        else if (a == 12'h3C8) m_key = d & 32'hFF;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // each rising edge of the slow pin is held for several fast cycles
    task automatic ticks(input int k);
        repeat (2 * k) begin
            repeat (5) @(posedge CLK);
            SLOW_CLOCK_INPUT_PIN <= !SLOW_CLOCK_INPUT_PIN;
        end
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        num_errors++;
        wrap_up();
    end
    initial begin
        {SRST, PSEL, PENABLE, PWRITE, SLOW_CLOCK_INPUT_PIN, KEY_VALID, IO_VALID} = 7'h40;
        {FLOPPY_PORT_ROUTING_SELECT, PP_MODE_DRIVE0_PP, PP_MODE_DRIVE1_PP} = 3'h0;
        {PADDR, IO_ADDR, PWDATA, KEY_CODE} = 64'h0;
        r = $urandom(32'hBB183675);
        repeat (20) @(posedge CLK);
        SRST <= 1'b0;
        for (int i = 0; i < 6; i++) apb(1'b0, regs_a[i], 32'h0);
        repeat (3) begin
            for (int i = 0; i < 6; i++) begin
                apb(1'b1, regs_a[i], $urandom);
                apb(1'b0, regs_a[i], 32'h0);
                @(negedge CLK);
                chk("absent flag", m_cfg & 1, SLOW_CLOCK_ABSENT_FLAG);
                chk("key off flag", (m_cfg >> 1) & 1, KEY_WAKE_LOGIC_OFF);
            end
        end
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, 12'h3C4, 32'(f));
            repeat (8) begin
                r = $urandom;
                @(posedge CLK);
                FLOPPY_PORT_ROUTING_SELECT <= r[0];
                PP_MODE_DRIVE0_PP <= r[1];
                PP_MODE_DRIVE1_PP <= r[2];
                e0 = (f == 0) ? r[1] : (f == 2 && !r[0]);
                e1 = (f == 0) ? r[2] : ((f == 1 || f == 2) && !r[0]);
                @(posedge CLK);
                @(negedge CLK);
                chk("drive0", e0, DRIVE0_ON_PP);
                chk("drive1", e1, DRIVE1_ON_PP);
            end
        end
        repeat (4) begin
            r = $urandom;
            apb(1'b1, 12'h180, r);
            apb(1'b1, 12'h184, r[15:8] | 32'h1);
            apb(1'b0, 12'h184, 32'h0);
            base = 12'(((m_hi & 15) << 8) | m_lo);
            for (int k = 0; k < 3; k++) begin
                @(posedge CLK);
                IO_VALID <= 1'b1;
                IO_ADDR <= (k == 2) ? base ^ (12'h002 << (r[19:16] % 11)) : base | 12'(k);
                @(posedge CLK);
                IO_VALID <= 1'b0;
                @(negedge CLK);
                chk("midi select", k != 2, MIDI_SELECT);
            end
        end
        // wake logic off, then slow clock absent, then running
        for (int c = 2; c >= 0; c--) begin
            r = $urandom;
            apb(1'b1, 12'h3C0, 32'(c));
            apb(1'b1, 12'h3C8, r[7:0]);
            @(posedge CLK);
            KEY_VALID <= 1'b1;
            KEY_CODE <= r[7:0];
            @(posedge CLK);
            KEY_VALID <= 1'b0;
            ticks(3);
            @(negedge CLK);
            chk("wake event", c == 0, WAKE_EVENT);
            apb(1'b1, 12'h3CC, 32'h1);
            @(negedge CLK);
            chk("wake cleared", 0, WAKE_EVENT);
        end
        // presence status: clear all, starve the watchdog, then one slow edge
        apb(1'b1, 12'h3CC, 32'h7);
        apb(1'b0, 12'h3CC, 32'h0);
        repeat (`SCR_SLOW_LOST_CYCLES) @(posedge CLK);
        m_st = 4;
        apb(1'b0, 12'h3CC, 32'h0);
        ticks(1);
        m_st = 6;
        apb(1'b0, 12'h3CC, 32'h0);
        // second reset in mid-run brings every register back to its reset value
        @(posedge CLK);
        SRST <= 1'b1;
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        m_hi = 3;
        m_lo = 8'h30;
        m_cfg = 0;
        m_rt = 0;
        m_key = 0;
        m_st = 0;
        for (int i = 0; i < 6; i++) apb(1'b0, regs_a[i], 32'h0);
        apb(1'b0, 12'h3CC, 32'h0);
        @(negedge CLK);
        chk("wake after reset", 0, WAKE_EVENT);
        chk("absent after reset", 0, SLOW_CLOCK_ABSENT_FLAG);
        chk("key off after reset", 0, KEY_WAKE_LOGIC_OFF);
        wrap_up();
    end
endmodule
`default_nettype wire
